// ---- bench/umr_link_partner.sv ----
`timescale 1ns/1ns
// ====
// Link partner returning completion quanta
module umr_link_partner (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Request and reply
  input wire logic issue_in,
  input wire logic [7:0] quanta_in,
  output logic rcvd_out
);
  logic [7:0] pend_r;
  // One quantum every other cycle while data is owed
  always_ff @(posedge sys_clk_in) begin
    rcvd_out <= 1'b0;
    if (!reset_n_in) begin
      pend_r <= 8'h0;
    end else if (issue_in) begin
      pend_r <= quanta_in;
    end else if (!rcvd_out && pend_r != 8'h0) begin
      pend_r <= pend_r - 8'h1;
      rcvd_out <= 1'b1;
    end
  end
endmodule

// ---- bench/umr_properties.sv ----
`timescale 1ns/1ns
// ====
// Port checker
module umr_properties (
  // Bus side
  input wire logic sys_clk_in, reset_n_in, wb_cyc_in, wb_we_in, wb_ack_out,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in, wb_dat_out,
  // Block side
  input wire logic rd_issue_in, rd_quantum_rcvd_in, rd_next_ok_out,
  input wire logic [7:0] rd_quanta_in, wr_frag_bytes_out,
  input wire logic det_start_in, det_busy_out, det_sample_out,
  input wire logic [2:0] drive_lvl_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Write to the top byte lands
  sequence wr_hi_s(a);
    wb_ack_out && wb_we_in && wb_adr_in == a && wb_sel_in[3];
  endsequence
  sequence quiet_s;
    det_busy_out && !det_sample_out [*8];
  endsequence
  frag_map_a: assert property (wr_hi_s(8'h68) |-> wr_frag_bytes_out ==
    (wb_dat_in[31] ? 8'h80 : wb_dat_in[30] ? 8'h40 : 8'h20))
    else $error("write split wrong");
  drive_map_a: assert property (wr_hi_s(8'h6c) |->
    drive_lvl_out == wb_dat_in[30:28]) else $error("drive level wrong");
  rsvd_low_a: assert property (wb_ack_out && !wb_we_in &&
    wb_adr_in == 8'h68 |-> wb_dat_out[26:0] == 27'h0)
    else $error("reserved bits set");
  rsvd_top_a: assert property (wb_ack_out && !wb_we_in &&
    wb_adr_in == 8'h6c |-> !wb_dat_out[31]) else $error("bit 31 set");
  pace_big_a: assert property (rd_issue_in && rd_next_ok_out &&
    rd_quanta_in > 8'h08 |=> !rd_next_ok_out) else $error("pacing open");
  pace_hold_a: assert property (!rd_next_ok_out &&
    !rd_quantum_rcvd_in && !wb_cyc_in |=> !rd_next_ok_out)
    else $error("pacing opened early");
  det_busy_a: assert property (det_start_in && !det_busy_out |=>
    quiet_s) else $error("detect wait short");
  det_span_a: assert property ($rose(det_busy_out) |->
    ##[10:500] det_sample_out) else $error("detect sample late");
endmodule
bind umr_top umr_properties u_props (.sys_clk_in(sys_clk_in),
  .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in), .wb_we_in(wb_we_in),
  .wb_ack_out(wb_ack_out), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
  .rd_issue_in(rd_issue_in), .rd_quantum_rcvd_in(rd_quantum_rcvd_in),
  .rd_next_ok_out(rd_next_ok_out), .rd_quanta_in(rd_quanta_in),
  .wr_frag_bytes_out(wr_frag_bytes_out), .det_start_in(det_start_in),
  .det_busy_out(det_busy_out), .det_sample_out(det_sample_out),
  .drive_lvl_out(drive_lvl_out));

// ---- bench/upstream_request_and_phy_ctrl_tb.sv ----
`timescale 1ns/1ns
// ====
// Testbench
module upstream_request_and_phy_ctrl_tb;
  logic sys_clk_in = '0, reset_n_in = '0, wb_cyc_in = '0, wb_stb_in = '0;
  logic wb_we_in = '0, rd_issue_in = '0, det_start_in = '0;
  logic [7:0] wb_adr_in = '0, rd_quanta_in = '0, wr_frag_bytes_out;
  logic [3:0] wb_sel_in = '0;
  logic [31:0] wb_dat_in = '0, wb_dat_out, rv;
  logic wb_ack_out, rd_quantum_rcvd_in, rd_next_ok_out, det_busy_out;
  logic det_sample_out, drive_rsvd_out, cdr_en;
  logic [1:0] cdr_gain, sigdet, crf;
  logic [3:0] ofs;
  logic [4:0] de_b, lvl_b;
  logic [2:0] eq_stage_en_out, drive_lvl_out;
  int miscompares = 0, checked = 0, cycles = 0, got = 0, n, b;
  int det_cyc[8] = '{10, 20, 40, 50, 100, 200, 400, 500};
  always #50 sys_clk_in = !sys_clk_in;
  umr_top dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .rd_issue_in(rd_issue_in), .rd_quanta_in(rd_quanta_in),
    .rd_quantum_rcvd_in(rd_quantum_rcvd_in),
    .rd_next_ok_out(rd_next_ok_out), .det_start_in(det_start_in),
    .wr_frag_bytes_out(wr_frag_bytes_out), .det_busy_out(det_busy_out),
    .det_sample_out(det_sample_out), .eq_stage_en_out(eq_stage_en_out),
    .cdr_2nd_en_out(cdr_en), .cdr_gain_out(cdr_gain),
    .sigdet_lvl_out(sigdet), .crf_thresh_out(crf), .ofs_en_out(ofs),
    .de_base_out(de_b), .lvl_base_out(lvl_b),
    .drive_lvl_out(drive_lvl_out), .drive_rsvd_out(drive_rsvd_out));
  umr_link_partner peer (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .issue_in(rd_issue_in && rd_next_ok_out), .quanta_in(rd_quanta_in),
    .rcvd_out(rd_quantum_rcvd_in));
  // Quantum counter and watchdog
  always @(posedge sys_clk_in) begin
    got <= got + int'(rd_quantum_rcvd_in === 1'b1);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  task results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", s, exp, seen);
    end
  endtask
  // Classic single bus cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge sys_clk_in);
    {wb_cyc_in, wb_stb_in, wb_we_in} <= {2'h3, w};
    {wb_adr_in, wb_dat_in, wb_sel_in} <= {a, d, s};
    do @(posedge sys_clk_in); while (wb_ack_out !== 1'b1);
    rv = wb_dat_out;
    {wb_cyc_in, wb_stb_in} <= 2'h0;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    wb(0, 8'h68, 0, 4'hf);
    chk("req", rv, 32'hb800_0000);
    wb(0, 8'h6c, 0, 4'hf);
    chk("phy", rv, 32'h09b4_3612);
    chk("phy_out", {ofs, de_b, lvl_b, crf, sigdet, cdr_gain, cdr_en},
      {4'h0, 5'h0d, 5'h13, 2'h3, 2'h1, 2'h2, 1'h0});
    wb(1, 8'h68, '1, 4'hf);
    wb(0, 8'h68, 0, 4'hf);
    chk("req_ro", rv, 32'hf800_0000);
    wb(1, 8'h6c, '1, 4'hf);
    wb(0, 8'h6c, 0, 4'hf);
    chk("phy_ro", rv, 32'h7fff_ffff);
    chk("phy_set", {ofs, de_b, lvl_b, crf, sigdet, cdr_gain, cdr_en},
      {4'hf, 5'h1f, 5'h1f, 2'h3, 2'h3, 2'h3, 1'h1});
    wb(0, 8'h74, 0, 4'hf);
    chk("unmap", rv, 0);
    for (int i = 0; i < 4; i++) begin
      wb(1, 8'h68, i << 30, 4'h8);
      chk("frag", wr_frag_bytes_out, 32'h20 << (i > 1 ? 2 : i));
    end
    $display("test regs done");
    // Each pacing code against a ten-quantum read
    for (int i = 0; i < 8; i++) begin
      wb(1, 8'h68, i << 27, 4'h8);
      b = got;
      @(posedge sys_clk_in);
      {rd_issue_in, rd_quanta_in} <= {1'b1, 8'h0a};
      @(posedge sys_clk_in);
      rd_issue_in <= 1'b0;
      repeat (40) @(negedge sys_clk_in) if (rd_next_ok_out === 1'b1) break;
      chk("left", 10 - (got - b), i > 3 ? 8 : (1 << i) >> 1);
      repeat (40) @(negedge sys_clk_in) if (got - b == 10) break;
    end
    $display("test pacing done");
    // Detect delay, equalizer and drive codes
    for (int i = 0; i < 8; i++) begin
      wb(1, 8'h6c, (i << 28) | (i << 3) | i, 4'hf);
      chk("eq", eq_stage_en_out, i);
      chk("drv", drive_lvl_out, i);
      chk("drv_rsv", drive_rsvd_out, i > 4);
      @(posedge sys_clk_in);
      det_start_in <= 1'b1;
      @(posedge sys_clk_in);
      det_start_in <= 1'b0;
      n = 0;
      repeat (600) begin
        @(negedge sys_clk_in);
        if (det_sample_out === 1'b1) break;
        @(posedge sys_clk_in);
        n++;
      end
      chk("det", n, det_cyc[i]);
    end
    $display("test phy done");
    results();
  end
endmodule

// ---- hw/umr_det_timer.sv ----
`timescale 1ns/1ns
// Waits the selected delay after start, then pulses sample
module umr_det_timer (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Control
  input wire logic start_in,
  input wire logic [2:0] sel_in,
  // Result
  output logic busy_out,
  output logic sample_out
);
  import umr_pkg::*;

  // Delay in clock cycles for a code, rounded up
  function automatic logic [UMR_DET_CW-1:0] det_cycles(
      input logic [2:0] code);
    int ns;
    case (code)
      3'h0: ns = UMR_DET_NS_0;
      3'h1: ns = UMR_DET_NS_1;
      3'h2: ns = UMR_DET_NS_2;
      3'h3: ns = UMR_DET_NS_3;
      3'h4: ns = UMR_DET_NS_4;
      3'h5: ns = UMR_DET_NS_5;
      3'h6: ns = UMR_DET_NS_6;
      default: ns = UMR_DET_NS_7;
    endcase
    det_cycles = UMR_DET_CW'((ns + UMR_NS_PER_CYC - 1) / UMR_NS_PER_CYC);
  endfunction

  logic [UMR_DET_CW-1:0] cnt_r;

  // Count down; delay is latched at start
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      cnt_r <= '0;
      busy_out <= 1'b0;
      sample_out <= 1'b0;
    end else begin
      sample_out <= 1'b0;
      if (start_in && !busy_out) begin
        cnt_r <= det_cycles(sel_in);
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (cnt_r == UMR_DET_CW'(1)) begin
          busy_out <= 1'b0;
          sample_out <= 1'b1;
        end
        cnt_r <= cnt_r - UMR_DET_CW'(1);
      end
    end
  end
endmodule

// ---- hw/umr_pkg.sv ----
package umr_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] UMR_OFS_REQ_CTRL = 8'h68;
  localparam logic [7:0] UMR_OFS_PHY_TUNE = 8'h6c;
  // ==========================================================
  // Field positions
  localparam int UMR_PACE_LSB = 27;
  localparam int UMR_FRAG_LSB = 30;
  localparam int UMR_DET_LSB = 0;
  localparam int UMR_EQ_LSB = 3;
  localparam int UMR_CDR_EN_BIT = 7;
  localparam int UMR_CDR_GAIN_LSB = 8;
  localparam int UMR_SIGDET_LSB = 10;
  localparam int UMR_CRF_LSB = 12;
  localparam int UMR_DEOFS_MRG_BIT = 14;
  localparam int UMR_DEOFS_NRM_BIT = 15;
  localparam int UMR_BOFS_NRM_BIT = 16;
  localparam int UMR_BOFS_MRG_BIT = 17;
  localparam int UMR_DE_BASE_LSB = 18;
  localparam int UMR_LVL_BASE_LSB = 23;
  localparam int UMR_DRIVE_LSB = 28;
  // ==========================================================
  // Writable masks and reset values
  localparam logic [31:0] UMR_REQ_WMASK = 32'hf800_0000;
  localparam logic [31:0] UMR_PHY_WMASK = 32'h7fff_ffff;
  localparam logic [2:0] UMR_PACE_RST = 3'h7;
  localparam logic [1:0] UMR_FRAG_RST = 2'h2;
  localparam logic [31:0] UMR_REQ_RST = 32'hb800_0000;
  localparam logic [31:0] UMR_PHY_RST = 32'h09b4_3612;
  // ==========================================================
  // Timing
  localparam int UMR_CLK_HZ = 10_000_000;
  localparam int UMR_DET_NS_0 = 1000;
  localparam int UMR_DET_NS_1 = 2000;
  localparam int UMR_DET_NS_2 = 4000;
  localparam int UMR_DET_NS_3 = 5000;
  localparam int UMR_DET_NS_4 = 10000;
  localparam int UMR_DET_NS_5 = 20000;
  localparam int UMR_DET_NS_6 = 40000;
  localparam int UMR_DET_NS_7 = 50000;
  localparam int UMR_NS_PER_CYC = 1_000_000_000 / UMR_CLK_HZ;
  localparam int UMR_DET_CW = 10;
endpackage

// ---- hw/umr_top.sv ----
`timescale 1ns/1ns
module umr_top (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Read channel pacing
  input wire logic rd_issue_in,
  input wire logic [7:0] rd_quanta_in,
  input wire logic rd_quantum_rcvd_in,
  output logic rd_next_ok_out,
  // Write fragmenting
  output logic [7:0] wr_frag_bytes_out,
  // Receiver detect
  input wire logic det_start_in,
  output logic det_busy_out,
  output logic det_sample_out,
  // PHY settings
  output logic [2:0] eq_stage_en_out,
  output logic cdr_2nd_en_out,
  output logic [1:0] cdr_gain_out,
  output logic [1:0] sigdet_lvl_out,
  output logic [1:0] crf_thresh_out,
  output logic [3:0] ofs_en_out,
  output logic [4:0] de_base_out,
  output logic [4:0] lvl_base_out,
  output logic [2:0] drive_lvl_out,
  output logic drive_rsvd_out
);
  import umr_pkg::*;

  // ==========================================================
  // Register bus
  logic [31:0] req_r;
  logic [31:0] phy_r;
  logic acc;
  logic hit_req;
  logic hit_phy;

  assign acc = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign hit_req = wb_adr_in == UMR_OFS_REQ_CTRL;
  assign hit_phy = wb_adr_in == UMR_OFS_PHY_TUNE;

  // Merge write data by byte lanes within writable bits
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wmask);
    logic [31:0] bm;
    bm = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
          {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}} & wmask;
    merge = (old & ~bm) | (wb_dat_in & bm);
  endfunction

  // Acknowledge one cycle after request, drop next cycle
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= acc;
    end
  end

  // Register storage
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      req_r <= UMR_REQ_RST;
      phy_r <= UMR_PHY_RST;
    end else if (acc && wb_we_in) begin
      if (hit_req) begin
        req_r <= merge(req_r, UMR_REQ_WMASK);
      end
      if (hit_phy) begin
        phy_r <= merge(phy_r, UMR_PHY_WMASK);
      end
    end
  end

  // Read data; unmapped reads zero
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (acc && !wb_we_in) begin
      if (hit_req) begin
        wb_dat_out <= req_r & UMR_REQ_WMASK;
      end else if (hit_phy) begin
        wb_dat_out <= phy_r & UMR_PHY_WMASK;
      end else begin
        wb_dat_out <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Read request pacing
  logic [2:0] pace;
  logic [7:0] left_r;
  logic [7:0] thresh;

  assign pace = req_r[UMR_PACE_LSB +: 3];

  // Quanta allowed outstanding before next request
  always_comb begin
    case (pace)
      3'h0: thresh = 8'h00;
      3'h1: thresh = 8'h01;
      3'h2: thresh = 8'h02;
      3'h3: thresh = 8'h04;
      default: thresh = 8'h08;
    endcase
  end

  // Track quanta still outstanding for previous request
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      left_r <= 8'h00;
    end else if (rd_issue_in && rd_next_ok_out) begin
      left_r <= rd_quanta_in;
    end else if (rd_quantum_rcvd_in && left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
    end
  end

  assign rd_next_ok_out = left_r <= thresh;

  // ==========================================================
  // Write fragment boundary
  always_comb begin
    case (req_r[UMR_FRAG_LSB +: 2])
      2'h0: wr_frag_bytes_out = 8'h20;
      2'h1: wr_frag_bytes_out = 8'h40;
      default: wr_frag_bytes_out = 8'h80;
    endcase
  end

  // ==========================================================
  // Receiver detect delay
  umr_det_timer u_det (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .start_in(det_start_in),
    .sel_in(phy_r[UMR_DET_LSB +: 3]),
    .busy_out(det_busy_out),
    .sample_out(det_sample_out)
  );

  // ==========================================================
  // PHY settings straight from register
  assign eq_stage_en_out = phy_r[UMR_EQ_LSB +: 3];
  assign cdr_2nd_en_out = phy_r[UMR_CDR_EN_BIT];
  assign cdr_gain_out = phy_r[UMR_CDR_GAIN_LSB +: 2];
  assign sigdet_lvl_out = phy_r[UMR_SIGDET_LSB +: 2];
  assign crf_thresh_out = phy_r[UMR_CRF_LSB +: 2];
  assign ofs_en_out = {phy_r[UMR_BOFS_MRG_BIT], phy_r[UMR_BOFS_NRM_BIT],
                       phy_r[UMR_DEOFS_NRM_BIT], phy_r[UMR_DEOFS_MRG_BIT]};
  assign de_base_out = phy_r[UMR_DE_BASE_LSB +: 5];
  assign lvl_base_out = phy_r[UMR_LVL_BASE_LSB +: 5];
  assign drive_lvl_out = phy_r[UMR_DRIVE_LSB +: 3];
  // Reserved margin codes flagged
  assign drive_rsvd_out = phy_r[UMR_DRIVE_LSB +: 3] > 3'h4;
endmodule
